// >>> verilog/cmmaio_supervisor.v
// cmmaio_supervisor.v: axis-side encoder and machine i/o supervisor, apb slave
// assumes pins arrive asynchronous to pclk; all are passed through two flops
//
// Summary of operation
// - encoder ports count quadrature edges 50 ns apart, 20 million counts/s
// - undriven a or b pair is reported as an encoder fault
// - readhead error input flags an encoder fault while asserted
// - four ports; absolute mode drives biss clock, reads data line
// - two active-low readhead limits; one shares the error line, selectable
// - machine inputs active when low, inactive when high or open
// - brake release outputs follow servo engagement
// - brake output polarity selectable, active low by default
// - active-low air solenoid output engages the solenoid
// - six general inputs and seven general outputs under software
// - drive disconnect suppresses servo drive, resumes from current position
// - drive disconnect polarity invertible by software
// - low air pressure raises a fatal fault removing motor power
// - crash sensor raises a fatal fault removing motor power
// - inner and outer limits per axis, each polarity selectable
// - inner limit stops all axes, then backs the axis off
// - outer limit removes servo power at once
// - outer limit fault cannot clear while its input stays active
//
// The placing of the registers and the APB register port were decided locally.
`include "cmmaio_consts.vh"
`default_nettype none
module cmmaio_supervisor #(
    parameter NPORT = 4,
    parameter POS_W = 32
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [3:0] enc_a_p,
    input wire [3:0] enc_a_n,
    input wire [3:0] enc_b_p_i,
    input wire [3:0] enc_b_n_i,
    output reg [3:0] enc_b_p_o,
    output reg [3:0] enc_b_n_o,
    output reg [3:0] enc_b_oe,
    input wire [3:0] enc_err_p,
    input wire [3:0] enc_err_n,
    input wire [3:0] enc_lim_q_n,
    input wire [5:0] gp_in_n,
    input wire drive_disconnect_input,
    input wire low_air_in,
    input wire crash_in,
    input wire [3:0] outer_pos_in,
    input wire [3:0] outer_neg_in,
    input wire [3:0] inner_pos_in,
    input wire [3:0] inner_neg_in,
    output reg [3:0] brake_out,
    output reg air_sol_n,
    output reg [6:0] gp_out,
    output reg amp_enable_n,
    output reg decel_all,
    output reg backoff_trig,
    output reg [1:0] backoff_axis,
    output reg backoff_dir,
    output reg drive_suppress,
    output reg resync_pos
);
// ****************************************
// input synchronisers
// ****************************************
localparam SW = 53;
wire [SW-1:0] raw = {enc_a_p, enc_a_n, enc_b_p_i, enc_b_n_i, enc_err_p, enc_err_n, enc_lim_q_n,
                     gp_in_n, drive_disconnect_input, low_air_in, crash_in,
                     outer_pos_in, outer_neg_in, inner_pos_in, inner_neg_in};
reg [SW-1:0] s1_r, s2_r;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        s1_r <= {SW{1'b1}};
        s2_r <= {SW{1'b1}};
    end else begin
        s1_r <= raw;
        s2_r <= s1_r;
    end
end
wire [3:0] ap = s2_r[52:49];
wire [3:0] an = s2_r[48:45];
wire [3:0] bp = s2_r[44:41];
wire [3:0] bn = s2_r[40:37];
wire [3:0] ep = s2_r[36:33];
wire [3:0] en = s2_r[32:29];
wire [3:0] lq = s2_r[28:25];
wire [5:0] gpi = ~s2_r[24:19];
wire dd_raw = s2_r[18];
wire air_raw = s2_r[17];
wire crash_raw = s2_r[16];
wire [15:0] lim_raw = s2_r[15:0];
// ****************************************
// registers
// ****************************************
reg [15:0] ctrl_r;
reg [15:0] liminv_r;
reg [6:0] gpo_r;
reg [2:0] fatal_r;
reg [3:0] ill_st_r, bfail_st_r;
reg [3:0] bstart_r;
wire [3:0] abs_m = ctrl_r[`CMMAIO_C_ABS];
wire [3:0] lsel = ctrl_r[`CMMAIO_C_LSEL];
// ****************************************
// machine input decode
// ****************************************
// raw pins idle high through pull-ups; invert bit selects active high
wire dd_act = ~dd_raw ^ ctrl_r[`CMMAIO_C_DDINV];
wire air_act = ~air_raw ^ ctrl_r[`CMMAIO_C_AIRINV];
wire crash_act = ~crash_raw ^ ctrl_r[`CMMAIO_C_CRINV];
wire [15:0] lim_act = ~lim_raw ^ liminv_r;
wire [3:0] outer_p = lim_act[15:12];
wire [3:0] outer_n = lim_act[11:8];
wire [3:0] inner_p = lim_act[7:4];
wire [3:0] inner_n = lim_act[3:0];
wire outer_any = |(outer_p | outer_n);
wire [3:0] inner_ax = inner_p | inner_n;
wire [2:0] cause = {outer_any, air_act, crash_act};
// drive disconnected: the input reads active when the drives are clutched
wire unclutched = ~dd_act;
wire servo_on = ctrl_r[`CMMAIO_C_SERVO] & ~|fatal_r & ~|cause & ~unclutched;
// ****************************************
// encoder ports
// ****************************************
wire [POS_W-1:0] pos_w [0:NPORT-1];
wire [3:0] hiz_w, ill_w, ma_w, busy_w, fail_w;
// readhead error is low-true differential; on a limit-use port the line is limit p
wire [3:0] err_act = ~ep & en & ~lsel;
wire [3:0] limp_act = ~ep & lsel;
wire [3:0] limq_act = ~lq;
wire [3:0] enc_fault = hiz_w | err_act;
genvar g;
generate
    for (g = 0; g < NPORT; g = g + 1) begin : chan
        cmmaio_enc_chan #(
            .POS_W(POS_W)
        ) u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .abs_mode(abs_m[g]),
            .a_p(ap[g]),
            .a_n(an[g]),
            .b_p(bp[g]),
            .b_n(bn[g]),
            .start(bstart_r[g]),
            .pos_r(pos_w[g]),
            .hiz_r(hiz_w[g]),
            .ill_r(ill_w[g]),
            .ma_r(ma_w[g]),
            .busy_r(busy_w[g]),
            .fail_r(fail_w[g])
        );
    end
endgenerate
// ****************************************
// apb slave
// ****************************************
// zero-wait slave: read data is built in the setup cycle
wire setup = psel & ~penable;
wire wr_go = psel & penable & pready & pwrite;
wire [31:0] w = pwdata;
wire pos_sel = (paddr[7:4] == 4'h2);
wire [1:0] pidx = paddr[3:2];
reg [31:0] rd_nxt;
reg hit_nxt;
always @* begin
    rd_nxt = 32'h0000_0000;
    hit_nxt = 1'b1;
    if (pos_sel && paddr[1:0] == 2'b00) begin
        rd_nxt = pos_w[pidx];
    end else begin
        case (paddr)
            `CMMAIO_A_CTRL: rd_nxt = {16'h0000, ctrl_r};
            `CMMAIO_A_LIMINV: rd_nxt = {16'h0000, liminv_r};
            `CMMAIO_A_GPOUT: rd_nxt = {25'h0000000, gpo_r};
            `CMMAIO_A_FAULT: rd_nxt = {22'h000000, unclutched, servo_on, 5'h00, fatal_r};
            `CMMAIO_A_INPUT: rd_nxt = {lim_act, 10'h000, gpi};
            `CMMAIO_A_ENC: rd_nxt = {bfail_st_r, busy_w, limq_act, limp_act,
                                     err_act, ill_st_r, enc_fault, hiz_w};
            `CMMAIO_A_BISS: rd_nxt = {28'h0000000, busy_w};
            default: hit_nxt = 1'b0;
        endcase
    end
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0000_0000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= 1'b1;
        if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr <= ~hit_nxt | (pwrite & pos_sel);
        end
    end
end
// ****************************************
// control registers and sticky status
// ****************************************
wire wr_ctrl = wr_go & (paddr == `CMMAIO_A_CTRL);
wire wr_fault = wr_go & (paddr == `CMMAIO_A_FAULT);
wire wr_enc = wr_go & (paddr == `CMMAIO_A_ENC);
wire [2:0] fclr = wr_fault ? w[2:0] : 3'h0;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl_r <= `CMMAIO_CTRL_RST;
        liminv_r <= 16'h0000;
        gpo_r <= 7'h00;
        fatal_r <= 3'h0;
        ill_st_r <= 4'h0;
        bfail_st_r <= 4'h0;
        bstart_r <= 4'h0;
    end else begin
        bstart_r <= 4'h0;
        if (wr_ctrl)
            ctrl_r <= w[15:0];
        if (wr_go && paddr == `CMMAIO_A_LIMINV)
            liminv_r <= w[15:0];
        if (wr_go && paddr == `CMMAIO_A_GPOUT)
            gpo_r <= w[6:0];
        if (wr_go && paddr == `CMMAIO_A_BISS)
            bstart_r <= w[3:0];
        // a clear only lands once the cause is gone; an active cause re-sets
        fatal_r <= (fatal_r & ~(fclr & ~cause)) | cause;
        // set wins over a same-cycle clear
        ill_st_r <= (ill_st_r & ~(wr_enc ? w[11:8] : 4'h0)) | ill_w;
        bfail_st_r <= (bfail_st_r & ~(wr_enc ? w[31:28] : 4'h0)) | fail_w;
    end
end
// outer bit of fatal_r stays set while outer_any holds, so the switch must be left first
// ****************************************
// machine outputs
// ****************************************
reg [3:0] inner_d_r;
reg unclutch_d_r;
wire [3:0] inner_new = inner_ax & ~inner_d_r;
reg [1:0] ax_nxt;
integer i;
always @* begin
    ax_nxt = 2'b00;
    for (i = NPORT - 1; i >= 0; i = i - 1) begin
        if (inner_new[i])
            ax_nxt = i[1:0];
    end
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        inner_d_r <= 4'h0;
        unclutch_d_r <= 1'b0;
        enc_b_p_o <= 4'h0;
        enc_b_n_o <= 4'h0;
        enc_b_oe <= 4'h0;
        brake_out <= 4'hF;
        air_sol_n <= 1'b1;
        gp_out <= 7'h00;
        amp_enable_n <= 1'b1;
        decel_all <= 1'b0;
        backoff_trig <= 1'b0;
        backoff_axis <= 2'b00;
        backoff_dir <= 1'b0;
        drive_suppress <= 1'b0;
        resync_pos <= 1'b0;
    end else begin
        inner_d_r <= inner_ax;
        unclutch_d_r <= unclutched;
        // b pair turns into the biss clock output in absolute mode
        enc_b_p_o <= ma_w;
        enc_b_n_o <= ~ma_w;
        enc_b_oe <= abs_m;
        brake_out <= {4{servo_on ~^ ctrl_r[`CMMAIO_C_BRKINV]}};
        air_sol_n <= ~ctrl_r[`CMMAIO_C_SOL];
        gp_out <= gpo_r;
        amp_enable_n <= ~servo_on;
        drive_suppress <= unclutched;
        resync_pos <= unclutch_d_r & ~unclutched;
        decel_all <= |inner_ax;
        backoff_trig <= |inner_new;
        if (|inner_new) begin
            backoff_axis <= ax_nxt;
            // back off away from the switch that tripped
            backoff_dir <= ~inner_p[ax_nxt];
        end
    end
end
endmodule
`default_nettype wire

// >>> verilog/cmmaio_consts.vh
// cmmaio_consts.vh: constants of the axis i/o supervisor
// assumes a 250 MHz pclk and a 32-bit apb register bus
`ifndef CMMAIO_CONSTS_VH
`define CMMAIO_CONSTS_VH
// ****************************************
// timing
// ****************************************
`define CMMAIO_CLK_PS 4000
`define CMMAIO_EDGE_NS 50
`define CMMAIO_EDGE_CYC ((`CMMAIO_EDGE_NS * 1000) / `CMMAIO_CLK_PS)
`define CMMAIO_HIZ_NS 1000
`define CMMAIO_HIZ_CYC ((`CMMAIO_HIZ_NS * 1000) / `CMMAIO_CLK_PS)
`define CMMAIO_MA_HALF 10
`define CMMAIO_BISS_WAIT 64
// ****************************************
// register offsets
// ****************************************
`define CMMAIO_A_CTRL 8'h00
`define CMMAIO_A_LIMINV 8'h04
`define CMMAIO_A_GPOUT 8'h08
`define CMMAIO_A_FAULT 8'h0C
`define CMMAIO_A_INPUT 8'h10
`define CMMAIO_A_ENC 8'h14
`define CMMAIO_A_BISS 8'h18
`define CMMAIO_A_POS 8'h20
// ****************************************
// control fields
// ****************************************
`define CMMAIO_C_SERVO 0
`define CMMAIO_C_BRKINV 1
`define CMMAIO_C_DDINV 2
`define CMMAIO_C_AIRINV 3
`define CMMAIO_C_CRINV 4
`define CMMAIO_C_SOL 5
`define CMMAIO_C_ABS 11:8
`define CMMAIO_C_LSEL 15:12
`define CMMAIO_CTRL_RST 16'h0000
// fault bits
`define CMMAIO_F_CRASH 0
`define CMMAIO_F_AIR 1
`define CMMAIO_F_OUTER 2
// per-port encoder status bits
`define CMMAIO_E_ILL 2
`define CMMAIO_E_BFAIL 6
`endif

// >>> verilog/cmmaio_enc_chan.v
// cmmaio_enc_chan.v: one encoder port, quadrature counter or biss master
// assumes inputs already synchronised to pclk
`include "cmmaio_consts.vh"
`default_nettype none
module cmmaio_enc_chan #(
    parameter POS_W = 32
) (
    input wire pclk,
    input wire presetn,
    input wire abs_mode,
    input wire a_p,
    input wire a_n,
    input wire b_p,
    input wire b_n,
    input wire start,
    output reg [POS_W-1:0] pos_r,
    output reg hiz_r,
    output reg ill_r,
    output reg ma_r,
    output reg busy_r,
    output reg fail_r
);
// ****************************************
// quadrature
// ****************************************
localparam [7:0] POS_N = POS_W;
wire a = a_p & ~a_n;
wire b = b_p & ~b_n;
wire bad = (a_p == a_n) | (~abs_mode & (b_p == b_n));
reg pa_r, pb_r;
reg [9:0] hcnt_r;
reg [7:0] bcnt_r, div_r;
reg ack_r, run_r;
reg [POS_W-1:0] sh_r;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pa_r <= 1'b0;
        pb_r <= 1'b0;
        hcnt_r <= 10'h000;
        hiz_r <= 1'b0;
        ill_r <= 1'b0;
        pos_r <= {POS_W{1'b0}};
        ma_r <= 1'b1;
        busy_r <= 1'b0;
        fail_r <= 1'b0;
        bcnt_r <= 8'h00;
        div_r <= 8'h00;
        ack_r <= 1'b0;
        run_r <= 1'b0;
        sh_r <= {POS_W{1'b0}};
    end else begin
        pa_r <= a;
        pb_r <= b;
        ill_r <= 1'b0;
        fail_r <= 1'b0;
        // undriven pair reads as equal halves; filter glitches on edges
        if (!bad)
            hcnt_r <= 10'h000;
        else if (hcnt_r != `CMMAIO_HIZ_CYC)
            hcnt_r <= hcnt_r + 10'h001;
        hiz_r <= (hcnt_r == `CMMAIO_HIZ_CYC);
        if (!abs_mode && (a != pa_r) && (b != pb_r))
            ill_r <= 1'b1;
        else if (!abs_mode && ((a != pa_r) || (b != pb_r))) begin
            if (pa_r ^ b)
                pos_r <= pos_r - {{(POS_W-1){1'b0}}, 1'b1};
            else
                pos_r <= pos_r + {{(POS_W-1){1'b0}}, 1'b1};
        end
        // biss: ack low, start high, then POS_W data bits msb first
        if (!busy_r) begin
            ma_r <= 1'b1;
            if (start && abs_mode) begin
                busy_r <= 1'b1;
                bcnt_r <= 8'h00;
                div_r <= 8'h00;
                ack_r <= 1'b0;
                run_r <= 1'b0;
            end
        end else if (div_r != `CMMAIO_MA_HALF) begin
            div_r <= div_r + 8'h01;
        end else begin
            div_r <= 8'h00;
            ma_r <= ~ma_r;
            if (!ma_r) begin
                bcnt_r <= bcnt_r + 8'h01;
                if (run_r) begin
                    sh_r <= {sh_r[POS_W-2:0], a};
                    if (bcnt_r == POS_N) begin
                        pos_r <= {sh_r[POS_W-2:0], a};
                        busy_r <= 1'b0;
                    end
                end else if (!a) begin
                    ack_r <= 1'b1;
                end else if (ack_r) begin
                    run_r <= 1'b1;
                    bcnt_r <= 8'h01;
                end
                if (!run_r && bcnt_r == `CMMAIO_BISS_WAIT) begin
                    busy_r <= 1'b0;
                    fail_r <= 1'b1;
                end
            end
        end
    end
end
endmodule
`default_nettype wire

// >>> sim/cmmaio_supervisor_properties.sv
// cmmaio_supervisor_properties.sv: port-level checks of the axis i/o supervisor
// assumes binding to the supervisor top, with outer limit polarity left at default
`default_nettype none
module cmmaio_supervisor_props (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] outer_pos_in,
    input wire [3:0] outer_neg_in,
    input wire [3:0] brake_out,
    input wire air_sol_n,
    input wire [6:0] gp_out,
    input wire amp_enable_n,
    input wire decel_all,
    input wire backoff_trig,
    input wire drive_suppress,
    input wire resync_pos
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************************************
    // properties
    // ****************************************
    brake_group_a: assert property ((brake_out == 4'h0) || (brake_out == 4'hF))
        else $error("brake outputs disagree");
    brake_release_a: assert property ($fell(amp_enable_n) |-> ##[0:2] $changed(brake_out))
        else $error("brakes ignored servo engage");
    solenoid_drive_a: assert property (psel && penable && pwrite && paddr == 8'h00
        |-> ##2 (air_sol_n == !$past(pwdata[5], 2))) else $error("solenoid output wrong");
    gp_out_a: assert property (psel && penable && pwrite && paddr == 8'h08
        |-> ##2 (gp_out == $past(pwdata[6:0], 2))) else $error("general outputs wrong");
    clutch_off_a: assert property (drive_suppress [*2] |-> amp_enable_n)
        else $error("drives enabled while unclutched");
    resync_pulse_a: assert property ($fell(drive_suppress) |-> ##[0:1] resync_pos ##1 !resync_pos)
        else $error("no single resume pulse");
    outer_off_a: assert property ((outer_pos_in != 4'hF || outer_neg_in != 4'hF) [*4]
        |-> amp_enable_n) else $error("drives enabled on outer limit");
    inner_stop_a: assert property (backoff_trig |-> decel_all ##1 !backoff_trig)
        else $error("back-off without stop");
endmodule
`default_nettype wire

// >>> sim/cmmaio_encoder_model.sv
// cmmaio_encoder_model.sv: readheads on the four encoder ports
// assumes bench strobes; port 0 moves, ports 1 to 3 sit still with idle high data
`default_nettype none
module cmmaio_encoder_model (
    input wire logic go,
    input wire logic dir,
    input wire logic jump,
    input wire logic flt,
    input wire logic err,
    output logic [3:0] a_p,
    output logic [3:0] a_n,
    output logic [3:0] b_p,
    output logic [3:0] b_n,
    output logic [3:0] err_p,
    output logic [3:0] err_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] ph = 2'h0;
    logic tg = 1'h0;
    logic qa;
    // an undriven pair wanders rather than holding its last level
    always #3.3 tg = ~tg;
    // 1 ns offset keeps edges off the bench clock edges
    always @(posedge go) begin
        #1;
        repeat (8) #50 ph = dir ? ph - 2'h1 : ph + 2'h1;
    end
    always @(posedge jump) #1 ph = ph + 2'h2;
    assign qa = (ph == 2'h1) || (ph == 2'h2);
    assign a_p = {3'h7, flt ? tg : qa};
    assign a_n = {3'h0, flt ? tg : ~qa};
    assign b_p = {3'h0, ph[1]};
    assign b_n = {3'h7, ~ph[1]};
    assign err_p = {3'h7, ~err};
    assign err_n = {3'h0, err};
endmodule
`default_nettype wire

// >>> sim/tb_cmmaio_supervisor.sv
// tb_cmmaio_supervisor.sv: self-checking bench of the axis i/o supervisor
// assumes the encoder model and checker are compiled first
`include "cmmaio_consts.vh"
`default_nettype none
module tb_cmmaio_supervisor;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, air_sol_n, amp_enable_n, decel_all, backoff_trig, backoff_dir;
    logic [3:0] enc_a_p, enc_a_n, enc_b_p_i, enc_b_n_i, enc_b_p_o, enc_b_n_o, enc_b_oe, enc_err_p, enc_err_n;
    logic [3:0] enc_lim_q_n = 4'hF, outer_pos_in = 4'hF, outer_neg_in = 4'hF;
    logic [3:0] inner_pos_in = 4'hF, inner_neg_in = 4'hF, brake_out;
    logic [5:0] gp_in_n = 6'h2A;
    logic drive_disconnect_input = 1'h0, low_air_in = 1'h1, crash_in = 1'h1;
    logic drive_suppress, resync_pos, go = 1'h0, dir = 1'h0, jump = 1'h0, flt = 1'h0, err = 1'h0;
    logic seen_ma = 1'h0;
    int n_rs = 0, rs0 = 0;
    logic [6:0] gp_out;
    logic [1:0] backoff_axis;
    logic [2:0] trig_r = 3'h0;
    int n_errors = 0, check_count = 0, cyc = 0;
    cmmaio_supervisor dut (.*);
    cmmaio_encoder_model rh (.go, .dir, .jump, .flt, .err, .a_p(enc_a_p), .a_n(enc_a_n),
        .b_p(enc_b_p_i), .b_n(enc_b_n_i), .err_p(enc_err_p), .err_n(enc_err_n));
    initial forever #2 pclk = ~pclk;
    // ****************************************
    // tasks
    // ****************************************
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'h0, a, 32'h0);
        chk(rd & m, exp);
    endtask
    task automatic move(input logic d);
        dir <= d;
        go <= 1'h1;
        wt(2);
        go <= 1'h0;
        wt(110);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (resync_pos === 1'h1) n_rs <= n_rs + 1;
        if (enc_b_oe[1] === 1'h1 && enc_b_p_o[1] === 1'h0) seen_ma <= 1'h1;
        if (backoff_trig === 1'h1) trig_r <= {backoff_axis, backoff_dir};
        if (cyc == 20000) begin
            n_errors++;
            close_out;
        end
    end
    // ****************************************
    // tests
    // ****************************************
    initial begin
        wt(20);
        presetn <= 1'h1;
        wt(2);
        chk({brake_out, air_sol_n, amp_enable_n, gp_out}, 13'h1F80);
        apb(1'h1, `CMMAIO_A_GPOUT, 32'h55);
        wt(1);
        chk(gp_out, 7'h55);
        rchk(`CMMAIO_A_INPUT, 32'h15, 32'h3F);
        rchk(8'h1C, 32'h0, 32'hFFFFFFFF);
        chk(er, 1'h1);
        $display("test io ended");
        apb(1'h1, `CMMAIO_A_CTRL, 32'h1);
        wt(3);
        chk({amp_enable_n, brake_out}, 5'h0);
        apb(1'h1, `CMMAIO_A_CTRL, 32'h23);
        wt(3);
        chk({brake_out, air_sol_n}, 5'h1E);
        apb(1'h1, `CMMAIO_A_CTRL, 32'h1);
        rs0 = n_rs;
        drive_disconnect_input <= 1'h1;
        wt(5);
        chk({drive_suppress, amp_enable_n}, 2'h3);
        drive_disconnect_input <= 1'h0;
        wt(5);
        chk(n_rs - rs0, 32'h1);
        chk(amp_enable_n, 1'h0);
        apb(1'h1, `CMMAIO_A_CTRL, 32'h5);
        wt(4);
        chk(drive_suppress, 1'h1);
        apb(1'h1, `CMMAIO_A_CTRL, 32'h1);
        wt(4);
        $display("test servo ended");
        for (int k = 0; k < 3; k++) begin
            if (k == 0) crash_in <= 1'h0;
            if (k == 1) apb(1'h1, `CMMAIO_A_CTRL, 32'h9);
            if (k == 2) outer_neg_in <= 4'hB;
            wt(5);
            chk(amp_enable_n, 1'h1);
            apb(1'h1, `CMMAIO_A_FAULT, 32'h7);
            rchk(`CMMAIO_A_FAULT, 32'h1 << k, 32'h7);
            crash_in <= 1'h1;
            outer_neg_in <= 4'hF;
            if (k == 1) low_air_in <= 1'h0;
            wt(5);
            apb(1'h1, `CMMAIO_A_FAULT, 32'h7);
            rchk(`CMMAIO_A_FAULT, 32'h0, 32'h7);
            chk(amp_enable_n, 1'h0);
        end
        $display("test faults ended");
        inner_pos_in <= 4'hD;
        wt(5);
        chk({decel_all, trig_r}, 4'hA);
        inner_pos_in <= 4'hF;
        wt(5);
        chk(decel_all, 1'h0);
        apb(1'h1, `CMMAIO_A_LIMINV, 32'h8);
        wt(4);
        chk({decel_all, trig_r}, 4'hF);
        rchk(`CMMAIO_A_INPUT, 32'h80000, 32'hFFFF0000);
        apb(1'h1, `CMMAIO_A_LIMINV, 32'h0);
        $display("test limits ended");
        move(1'h0);
        rchk(`CMMAIO_A_POS, 32'h8, 32'hFFFFFFFF);
        move(1'h1);
        rchk(`CMMAIO_A_POS, 32'h0, 32'hFFFFFFFF);
        jump <= 1'h1;
        wt(10);
        rchk(`CMMAIO_A_ENC, 32'h100, 32'h100);
        rchk(`CMMAIO_A_POS, 32'h0, 32'hFFFFFFFF);
        flt <= 1'h1;
        wt(300);
        rchk(`CMMAIO_A_ENC, 32'h11, 32'h11);
        flt <= 1'h0;
        err <= 1'h1;
        wt(5);
        rchk(`CMMAIO_A_ENC, 32'h1010, 32'h1010);
        apb(1'h1, `CMMAIO_A_CTRL, 32'h1009);
        enc_lim_q_n <= 4'hE;
        wt(5);
        rchk(`CMMAIO_A_ENC, 32'h110000, 32'h110000);
        err <= 1'h0;
        apb(1'h1, `CMMAIO_A_CTRL, 32'h209);
        wt(3);
        chk({enc_b_oe[1], enc_b_p_o[1], enc_b_n_o[1]}, 3'h6);
        apb(1'h1, `CMMAIO_A_BISS, 32'h2);
        rchk(`CMMAIO_A_ENC, 32'h2000000, 32'h2000000);
        // a silent data line never acks, so the port gives up after its wait count of clock periods
        wt(1500);
        rchk(`CMMAIO_A_ENC, 32'h20000000, 32'h22000000);
        chk(seen_ma, 1'h1);
        $display("test encoder ended");
        close_out;
    end
endmodule
bind cmmaio_supervisor cmmaio_supervisor_props props_i (.*);
`default_nettype wire
